// ---- gwl_pkg.sv ----
// package for the gradient word link source: word layout, register map, timing
// assumes a 20 MHz system clock; the link clock arrives as an ordinary input
package gwl_pkg;
    localparam int WordW = 48;
    localparam int ParityBit = 47;
    localparam int AddrHi = 46;
    localparam int AddrLo = 37;
    localparam int DataHi = 36;
    localparam int DataLo = 17;
    localparam int LastBit = 2;
    localparam int ValidBit = 1;
    localparam int NextBit = 0;
    localparam int ListStopBit = 31;
    localparam int ListSelBit = 26;
    localparam int ListAddrHiTop = 29;
    localparam int ListAddrHiBot = 26;
    localparam int ListAddrLoTop = 25;
    localparam int ListAddrLoBot = 20;
    localparam int ListDataTop = 19;
    localparam logic [9:0] AddrX = 10'h000;
    localparam logic [9:0] AddrY = 10'h001;
    localparam logic [3:0] RegList32 = 4'h0;
    localparam logic [3:0] RegWordBLo = 4'h1;
    localparam logic [3:0] RegWordBHi = 4'h2;
    localparam logic [3:0] RegWordA = 4'h3;
    localparam logic [3:0] RegCtrl = 4'h4;
    localparam logic [3:0] RegStatus = 4'h5;
    localparam logic [3:0] RegCount = 4'h6;
    localparam int CtrlLastBit = 0;
    localparam int CtrlSkewBit = 1;
    localparam int CtrlListAddrHiEn = 2;
    localparam int WordANextBit = 34;
    localparam int DepthLog2 = 4;
    localparam int SkewPulseNs = 50;
    localparam int ClkNs = 50;
    localparam int SkewCycles = (SkewPulseNs + ClkNs - 1) / ClkNs;
    localparam logic [7:0] PowerUpDelay = 8'h10;
    localparam logic [31:0] ZeroWord = 32'h0000_0000;
    localparam logic [47:0] IdleWord = 48'h8000_0000_0007;
    typedef enum logic [1:0] {GWL_OPEN, GWL_AMP, GWL_PREEMPH, GWL_OTHER} gwl_far_e;
    typedef enum {GWL_BOOT, GWL_IDLE, GWL_SKEW} gwl_skew_e;
endpackage

// ---- gwl_word_if.sv ----
// interface between the word builder and its small queue memory
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface gwl_word_if;
    logic wrEn;
    logic [3:0] wrAddr;
    logic [47:0] wrData;
    logic [3:0] rdAddr;
    logic [47:0] rdData;
    modport owner (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ---- gwl_word_mem.sv ----
// small queue memory holding built link words; registered read data
// assumes a single clock shared with the owner
`timescale 1ns/100ps
module gwl_word_mem (
    // clock
    input wire logic clk,
    // access
    gwl_word_if.store mem
);
    logic [47:0] cells [16];
    logic [47:0] rdData_q;

    always_ff @(posedge clk) begin
        if (mem.wrEn) begin
            cells[mem.wrAddr] <= mem.wrData;
        end
        rdData_q <= cells[mem.rdAddr];
    end
    assign mem.rdData = rdData_q;
endmodule

// ---- gwl_source.sv ----
// gradient word link source: builds 48-bit words from a 32-bit list word or a
// 64-bit A/B pair, adds strobes and parity, launches on link clock rising edges
// assumes the link clock (2.5 MHz nominal) is sampled by clk and found by edge
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - words are 48 bits, top bit is parity over the rest
// - address in top ten below parity, data next twenty, reserved bits low
// - valid strobe active low marks address and data valid
// - next-gradient strobe active low, valid on its own
// - last flag active low, made by hardware when bus lacks it
// - one word launched per rising edge of the transfer clock
// - address zero selects X, address one selects Y
// - 32-bit bus: bits 19..0 data, 25..20 low address, 29..26 high address
// - list bit 31 stops sequencer, bit 26 selects timer; never sent
// - processor side carries data, address, last and next strobe only
// - valid, next, last and parity come from hardware on 32-bit path
// - 64-bit path takes word bits from same positions of word B; here B bits 47..18 and 3 land one place lower
// - 64-bit path next strobe comes from word A, no valid needed
// - parity always generated by this hardware
// - two pulled-up sense lines decoded into far-end kind, in status
// - skew trigger fires after power-up and on software request
// - parity makes whole word even over bits 0..47
module gwl_source (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    // link
    input wire logic linkClock,
    output logic [47:0] linkWord,
    output logic skewOptimizeTrigger,
    // far-end sense lines
    input wire logic farSense0,
    input wire logic farSense1
);
    import gwl_pkg::*;

    gwl_word_if wif ();
    gwl_word_mem uMem (
        .clk(clk),
        .mem(wif)
    );

    function automatic logic evenPar(input logic [46:0] w);
        return ^w;
    endfunction

    // builds a word from address, data and low-active strobes
    function automatic logic [47:0] buildWord(input logic [9:0] a, input logic [19:0] d,
                                             input logic lastN, input logic validN,
                                             input logic nextN);
        logic [46:0] body;
        body = '0;
        body[AddrHi:AddrLo] = a;
        body[DataHi:DataLo] = d;
        body[LastBit] = lastN;
        body[ValidBit] = validN;
        body[NextBit] = nextN;
        return {evenPar(body), body};
    endfunction

    logic [2:0] lcSync_q;
    logic [1:0] s0Sync_q, s1Sync_q;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] wordBLo_q, wordBLo_d, wordBHi_q, wordBHi_d;
    logic [4:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [31:0] rdData_q, rdData_d;
    logic [47:0] word_q, word_d;
    logic [31:0] sent_q, sent_d;
    logic pendNext_q, pendNext_d;
    logic drop_q, drop_d;
    logic memValid_q, memValid_d;
    logic stopped_q, stopped_d;
    logic timerSel_q, timerSel_d;
    gwl_skew_e skewSt_q, skewSt_d;
    logic [7:0] skewCnt_q, skewCnt_d;
    logic skewOut_q, skewOut_d;
    logic skewReq_q, skewReq_d;
    gwl_far_e far;
    logic linkRise, full, empty, haveWord;
    logic [47:0] newWord;
    logic pushWord;

    // link clock and sense lines cross into clk domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lcSync_q <= '0;
            s0Sync_q <= '0;
            s1Sync_q <= '0;
        end else begin
            lcSync_q <= {lcSync_q[1:0], linkClock};
            s0Sync_q <= {s0Sync_q[0], farSense0};
            s1Sync_q <= {s1Sync_q[0], farSense1};
        end
    end
    assign linkRise = lcSync_q[1] & ~lcSync_q[2];

    // far-end decode from pulled-up lines
    always_comb begin
        case ({s1Sync_q[1], s0Sync_q[1]})
            2'b11: far = GWL_OPEN;
            2'b00: far = GWL_AMP;
            2'b10: far = GWL_PREEMPH;
            default: far = GWL_OTHER;
        endcase
    end

    assign full = (wrPtr_q[4] != rdPtr_q[4]) && (wrPtr_q[3:0] == rdPtr_q[3:0]);
    assign empty = (wrPtr_q == rdPtr_q);

    always_comb begin
        ctrl_d = ctrl_q;
        wordBLo_d = wordBLo_q;
        wordBHi_d = wordBHi_q;
        // launched request clears; a same-cycle new request still wins
        pendNext_d = pendNext_q & ~(linkRise & (skewSt_q != GWL_SKEW));
        stopped_d = stopped_q;
        timerSel_d = timerSel_q;
        skewReq_d = skewReq_q;
        drop_d = drop_q;
        rdData_d = ZeroWord;
        newWord = '0;
        pushWord = 1'b0;
        if (regWrStb) begin
            case (regAddr)
                RegList32: begin
                    stopped_d = regWrData[ListStopBit] | stopped_q;
                    timerSel_d = regWrData[ListSelBit];
                    newWord = buildWord(
                        {ctrl_q[CtrlListAddrHiEn] ? regWrData[ListAddrHiTop:ListAddrHiBot]
                                                  : 4'h0,
                         regWrData[ListAddrLoTop:ListAddrLoBot]},
                        regWrData[ListDataTop:0],
                        ~ctrl_q[CtrlLastBit], 1'b0, 1'b1);
                    pushWord = ~stopped_q & ~regWrData[ListSelBit];
                end
                RegWordBLo: wordBLo_d = regWrData;
                RegWordBHi: begin
                    wordBHi_d = regWrData;
                    // B word bits 47..18 and 3, each one place lower
                    newWord = buildWord(regWrData[15:6],
                        {regWrData[5:0], wordBLo_q[31:18]},
                        wordBLo_q[3], 1'b0, 1'b1);
                    pushWord = 1'b1;
                end
                RegWordA: begin
                    pendNext_d = regWrData[WordANextBit - 32] | pendNext_d;
                end
                RegCtrl: begin
                    ctrl_d = regWrData;
                    if (regWrData[CtrlSkewBit]) begin
                        skewReq_d = 1'b1;
                    end
                    stopped_d = 1'b0;
                end
                default: ;
            endcase
        end
        if (pushWord && full) begin
            drop_d = 1'b1;
        end
        if (regRdStb) begin
            case (regAddr)
                RegCtrl: rdData_d = ctrl_q;
                RegWordBLo: rdData_d = wordBLo_q;
                RegWordBHi: rdData_d = wordBHi_q;
                RegStatus: rdData_d = {24'h00_0000, 1'b0, timerSel_q, drop_q, stopped_q,
                                       ~empty, pendNext_q, far};
                RegCount: rdData_d = sent_q;
                default: rdData_d = ZeroWord;
            endcase
            if (regAddr == RegStatus) begin
                drop_d = pushWord && full;
            end
        end
        if (skewSt_q == GWL_SKEW) begin
            skewReq_d = 1'b0;
        end
    end

    assign wif.wrEn = pushWord & ~full;
    assign wif.wrAddr = wrPtr_q[3:0];
    assign wif.wrData = newWord;
    assign wif.rdAddr = rdPtr_q[3:0];

    // launch: one word per link clock rising edge; strobes idle high
    always_comb begin
        wrPtr_d = wif.wrEn ? wrPtr_q + 5'd1 : wrPtr_q;
        rdPtr_d = rdPtr_q;
        memValid_d = ~empty;
        word_d = word_q;
        sent_d = sent_q;
        haveWord = memValid_q & ~empty;
        if (skewSt_q == GWL_SKEW) begin
            // all-low word stands beside the trigger pulse
            word_d = '0;
        end else if (linkRise) begin
            if (pendNext_q) begin
                word_d = buildWord(10'h000, 20'h0_0000, 1'b1, 1'b1, 1'b0);
            end else if (haveWord) begin
                word_d = wif.rdData;
                rdPtr_d = rdPtr_q + 5'd1;
                memValid_d = 1'b0;
                sent_d = sent_q + 32'd1;
            end else begin
                word_d = buildWord(10'h000, 20'h0_0000, 1'b1, 1'b1, 1'b1);
            end
        end
    end

    always_comb begin
        skewSt_d = skewSt_q;
        skewCnt_d = skewCnt_q;
        skewOut_d = 1'b0;
        case (skewSt_q)
            GWL_BOOT: begin
                skewCnt_d = skewCnt_q + 8'd1;
                if (skewCnt_q == PowerUpDelay) begin
                    skewSt_d = GWL_SKEW;
                    skewCnt_d = '0;
                end
            end
            GWL_IDLE: begin
                if (skewReq_q) begin
                    skewSt_d = GWL_SKEW;
                    skewCnt_d = '0;
                end
            end
            GWL_SKEW: begin
                skewOut_d = 1'b1;
                skewCnt_d = skewCnt_q + 8'd1;
                if (skewCnt_q == 8'(SkewCycles - 1)) begin
                    skewSt_d = GWL_IDLE;
                end
            end
            default: skewSt_d = GWL_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= ZeroWord;
            wordBLo_q <= ZeroWord;
            wordBHi_q <= ZeroWord;
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            rdData_q <= ZeroWord;
            word_q <= IdleWord;
            sent_q <= ZeroWord;
            pendNext_q <= 1'b0;
            drop_q <= 1'b0;
            memValid_q <= 1'b0;
            stopped_q <= 1'b0;
            timerSel_q <= 1'b0;
            skewSt_q <= GWL_BOOT;
            skewCnt_q <= '0;
            skewOut_q <= 1'b0;
            skewReq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            wordBLo_q <= wordBLo_d;
            wordBHi_q <= wordBHi_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            rdData_q <= rdData_d;
            word_q <= word_d;
            sent_q <= sent_d;
            pendNext_q <= pendNext_d;
            drop_q <= drop_d;
            memValid_q <= memValid_d;
            stopped_q <= stopped_d;
            timerSel_q <= timerSel_d;
            skewSt_q <= skewSt_d;
            skewCnt_q <= skewCnt_d;
            skewOut_q <= skewOut_d;
            skewReq_q <= skewReq_d;
        end
    end

    assign regRdData = rdData_q;
    assign linkWord = word_q;
    assign skewOptimizeTrigger = skewOut_q;
endmodule

// ---- gwl_source_monitor.sv ----
// checker on the ports of the gradient word link source
// assumes clk is the only clock and reset is async active high
`timescale 1ns/100ps
module gwl_source_monitor (
    // clock, reset and register port
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [31:0] regRdData,
    // link and sense lines
    input wire logic linkClock,
    input wire logic [47:0] linkWord,
    input wire logic skewOptimizeTrigger,
    input wire logic farSense0,
    input wire logic farSense1
);
    import gwl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_parity_even: assert property (
        !(linkWord[1] && linkWord[0]) |-> (^linkWord) == 1'b0) else $error("odd parity");
    a_reserved_low: assert property (
        linkWord[16:3] == 14'h0000) else $error("reserved bits not low");
    a_launch_edge: assert property (
        $changed(linkWord) && !skewOptimizeTrigger && !$past(skewOptimizeTrigger)
        |-> $past(linkClock, 2) || $past(linkClock, 3)) else $error("word off link edge");
    a_skew_blank: assert property (
        skewOptimizeTrigger |-> linkWord == 48'h0000_0000_0000) else $error("word during skew");
    a_skew_single: assert property (
        skewOptimizeTrigger |=> !skewOptimizeTrigger) else $error("skew pulse too long");
    a_powerup_skew: assert property (
        $fell(reset) |-> ##[15:20] skewOptimizeTrigger) else $error("no power-up skew");
    a_skew_request: assert property (
        regWrStb && regAddr == RegCtrl && regWrData[CtrlSkewBit] |-> ##[1:6] skewOptimizeTrigger)
        else $error("no requested skew");
    a_far_open: assert property (
        (farSense0 && farSense1)[*4] ##0 (regRdStb && regAddr == RegStatus)
        |=> regRdData[1:0] == 2'h0) else $error("open line not reported");
    c_valid_word: cover property (!linkWord[1]);
    c_next_word: cover property (!linkWord[0] && linkWord[1]);
    c_skew: cover property (skewOptimizeTrigger);
endmodule

// ---- gwl_far_receiver.sv ----
// far-end receiver model: makes the link clock, drives sense lines, captures words
// assumes the link word settles well inside one link clock period
`timescale 1ns/100ps
module gwl_far_receiver (
    // link
    output logic linkClock,
    input wire logic [47:0] linkWord,
    // sense lines
    input wire logic [1:0] farSel,
    output logic farSense0,
    output logic farSense1,
    // captured words
    output logic [47:0] rxWord,
    output logic rxTgl,
    output logic [19:0] dacX,
    output logic parityErr
);
    logic [19:0] preX;
    logic hit;
    assign farSense0 = farSel[0];
    assign farSense1 = farSel[1];
    // all-low word is the deskew pattern, never data
    assign hit = (linkWord != 48'h0000_0000_0000) && !(linkWord[1] && linkWord[0]);
    initial begin
        linkClock = 1'b0;
        rxTgl = 1'b0;
        rxWord = 48'h0000_0000_0000;
        dacX = 20'h0_0000;
        preX = 20'h0_0000;
        parityErr = 1'b0;
        #37;
        forever #200 linkClock = ~linkClock;
    end
    always @(posedge linkClock) begin
        if (hit) begin
            parityErr <= parityErr | (^linkWord);
            rxWord <= linkWord;
            rxTgl <= ~rxTgl;
        end
        if (hit && !linkWord[1] && linkWord[46:37] == 10'h000)
            preX <= linkWord[36:17];
        if (hit && !linkWord[1] && linkWord[46:37] == 10'h03F)
            preX <= 20'h0_0000;
        if (hit && !linkWord[0])
            dacX <= preX;
    end
endmodule

// ---- gwl_source_test.sv ----
// bench for the gradient word link source against a far-end receiver model
// assumes package, design, receiver model and checker are compiled first
`timescale 1ns/100ps
module gwl_source_test;
    import gwl_pkg::*;
    logic clk, reset, regWrStb, regRdStb, linkClock, skewOptimizeTrigger;
    logic farSense0, farSense1, rxTgl, parityErr, rdSeen;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData;
    logic [47:0] linkWord, rxWord, bw;
    logic [19:0] dacX, d;
    logic [9:0] a;
    logic [1:0] farSel;
    logic [1:0] far [4];
    logic [63:0] r;
    logic [47:0] expQ [$];
    logic [63:0] rdQ [$];
    int errors, checked;
    gwl_source gwl_source_inst (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .linkClock(linkClock), .linkWord(linkWord),
        .skewOptimizeTrigger(skewOptimizeTrigger), .farSense0(farSense0),
        .farSense1(farSense1));
    gwl_far_receiver gwl_far_receiver_inst (.linkClock(linkClock), .linkWord(linkWord),
        .farSel(farSel), .farSense0(farSense0), .farSense1(farSense1), .rxWord(rxWord),
        .rxTgl(rxTgl), .dacX(dacX), .parityErr(parityErr));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [47:0] mk(logic [9:0] ad, logic [19:0] dt, logic [2:0] s);
        logic [46:0] w;
        w = {ad, dt, 14'h0000, s};
        return {^w, w};
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
        @(posedge clk);
        regAddr <= ad;
        regWrData <= dt;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e);
        rdQ.push_back({m, e});
        @(posedge clk);
        regAddr <= ad;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
    endtask
    task automatic drain(input string name);
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        repeat (40) @(posedge clk);
        chk(48'(expQ.size()), 48'h0000_0000_0000, "words left");
        $display("test %s done", name);
    endtask
    task automatic waitSkew(input string name);
        int n;
        n = 0;
        while (skewOptimizeTrigger !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk(48'(n < 40), 48'h0000_0000_0001, "skew trigger");
        $display("test %s done", name);
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rdSeen) begin
            r = rdQ.pop_front();
            chk(48'(regRdData & r[63:32]), 48'(r[31:0]), "read");
        end
        rdSeen <= regRdStb;
    end
    always @(rxTgl)
        if ($time > 0)
            chk(rxWord, (expQ.size() != 0) ? expQ.pop_front() : 48'h0000_0000_0000, "word");
    initial begin
        regAddr = 4'h0;
        regWrData = 32'h0000_0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        rdSeen = 1'b0;
        farSel = 2'h3;
        far = '{2'h1, 2'h3, 2'h2, 2'h0};
        errors = 0;
        checked = 0;
        reset = 1'b1;
        void'($urandom(32'h8f94_27a7));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        waitSkew("power-up skew");
        for (int i = 0; i < 4; i++) begin
            farSel <= i[1:0];
            repeat (6) @(posedge clk);
            rd(RegStatus, 32'h0000_0003, {30'h0000_0000, far[i]});
        end
        rd(4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
        repeat (3) @(posedge clk);
        $display("test status done");
        for (int b = 0; b < 2; b++) begin
            wr(RegCtrl, (b == 0) ? 32'h0000_0000 : 32'h0000_0005);
            for (int i = 0; i < 6; i++) begin
                a = 10'($urandom);
                d = 20'($urandom);
                a[6] = 1'b0;
                if (b == 0)
                    a[9:6] = 4'h0;
                if (i == 3)
                    wr(RegList32, {6'h01, a[5:0], d});
                else begin
                    expQ.push_back(mk(a, d, {b == 0, 2'b01}));
                    wr(RegList32, {2'b00, a[9:6], a[5:0], d});
                end
            end
            drain("list words");
        end
        expQ.push_back(mk(a & 10'h03F, d, 3'b001));
        wr(RegList32, {2'b10, 4'h0, a[5:0], d});
        wr(RegList32, {12'h000, d});
        drain("stop marker");
        rd(RegStatus, 32'h0000_0038, 32'h0000_0010);
        wr(RegCtrl, 32'h0000_0000);
        expQ.push_back(mk(AddrY, d, 3'b101));
        wr(RegList32, {12'h001, d});
        drain("restart");
        for (int i = 0; i < 3; i++) begin
            bw = {10'($urandom), 20'($urandom), 14'h0000, 2'($urandom), 2'b00};
            expQ.push_back(mk(bw[47:38], bw[37:18], {bw[3], 2'b01}));
            wr(RegWordBLo, bw[31:0]);
            wr(RegWordBHi, {16'h0000, bw[47:32]});
        end
        drain("wide words");
        d = 20'($urandom);
        expQ.push_back(mk(AddrX, 20'h0_0000, 3'b110));
        wr(RegWordA, 32'h0000_0004);
        expQ.push_back(mk(AddrX, d, 3'b101));
        wr(RegList32, {12'h000, d});
        drain("next gradient");
        expQ.push_back(mk(AddrX, 20'h0_0000, 3'b110));
        wr(RegWordA, 32'h0000_0004);
        drain("second next gradient");
        rd(RegCount, 32'hFFFF_FFFF, 32'h0000_0010);
        chk(48'(dacX), 48'(d), "dac value");
        wr(RegCtrl, 32'h0000_0002);
        waitSkew("requested skew");
        chk(48'(parityErr), 48'h0000_0000_0000, "parity flag");
        summarize();
    end
    initial begin
        #2_000_000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        summarize();
    end
endmodule
bind gwl_source gwl_source_monitor gwl_source_monitor_inst (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .linkClock(linkClock), .linkWord(linkWord),
    .skewOptimizeTrigger(skewOptimizeTrigger), .farSense0(farSense0), .farSense1(farSense1));
